//--- src/clock_pll_pkg.sv
// Notes on behaviour
// - Divider select cleared halves the source clock; set passes it undivided.
// - With main clock off, only clock control and PLL registers take writes.
// - Setting the main clock enable while the PLL enable (bit 7) is set also enables the PLL clock.
// - After main clock enable, parameter writes wait for the core clock enable.
// - Denominator is sixteen bits: high byte 0x01, low byte 0x02, reset zero.
// - Numerator is sixteen bits: high byte 0x03, low byte 0x04, reset zero.
// - Integer multiplier codes 2 to 8 are direct; codes 0 and 1 are reserved.
// - Input divider codes 00 to 11 divide the pin clock by 1 to 4.
// - Integer setting bit 0 picks integer mode at 0, fractional at 1.
// - Offset 0x06 bit 0 is a read-only lock flag, reset zero.
// - PLL clock runs only with PLL enable and main clock enable; PLL off powers down.
package clock_pll_pkg;

  localparam logic [7:0] clock_control_offset = 8'h00;
  localparam logic [7:0] pll_denominator_high_offset = 8'h01;
  localparam logic [7:0] pll_denominator_low_offset = 8'h02;
  localparam logic [7:0] pll_numerator_high_offset = 8'h03;
  localparam logic [7:0] pll_numerator_low_offset = 8'h04;
  localparam logic [7:0] pll_integer_setting_offset = 8'h05;
  localparam logic [7:0] pll_lock_flag_offset = 8'h06;
  localparam logic [7:0] core_enable_offset = 8'h10;
  localparam logic [7:0] irq_status_offset = 8'h11;
  localparam logic [7:0] irq_mask_offset = 8'h12;
  localparam logic [7:0] param_base_offset = 8'h80;

  localparam int pll_enable_bit = 7;
  localparam int main_clock_source_select_bit = 3;
  localparam int master_clock_divider_select_bit = 1;
  localparam int main_clock_enable_bit = 0;
  localparam int int_mult_msb = 6;
  localparam int int_mult_lsb = 3;
  localparam int in_div_msb = 2;
  localparam int in_div_lsb = 1;
  localparam int pll_type_bit = 0;
  localparam int lock_bit = 0;
  localparam int core_clk_en_bit = 0;
  localparam int irq_lock_gained_bit = 0;
  localparam int irq_lock_lost_bit = 1;
  localparam int irq_write_refused_bit = 2;

  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [3:0] int_mult_min = 4'h2;
  localparam logic [3:0] int_mult_max = 4'h8;

  localparam int clk_sys_mhz = 250;
  localparam int lock_time_ns = 2000;
  localparam int lock_cycles = (lock_time_ns * clk_sys_mhz + 999) / 1000;

endpackage

//--- src/pll_lock_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Models PLL settling: the flag rises after the enable has held for a full count.
module pll_lock_timer #(
  parameter int lock_count = clock_pll_pkg::lock_cycles
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  // Status
  output logic locked_o
);

  localparam int cnt_width = $clog2(lock_count + 1);
  localparam logic [cnt_width-1:0] cnt_done = cnt_width'(lock_count);

  logic [cnt_width-1:0] cnt;
  logic [cnt_width-1:0] next_cnt;
  logic next_locked;

  always_comb begin
    next_cnt = cnt;
    next_locked = locked_o;
    if (!enable_i) begin
      next_cnt = '0;
      next_locked = 1'b0;
    end else if (cnt != cnt_done) begin
      next_cnt = cnt + cnt_width'(1);
    end else begin
      next_locked = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      locked_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      locked_o <= next_locked;
    end
  end

  chk_lock_needs_enable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(locked_o) |-> $past(enable_i, 1) && $past(cnt, 1) == cnt_done)
    else $error("lock rose without a full settling count");

endmodule

`default_nettype wire

//--- src/clock_pll_config_bank.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module clock_pll_config_bank #(
  parameter int lock_count = clock_pll_pkg::lock_cycles
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Clock pins
  input wire logic ext_clk_pin_i,
  input wire logic pll_clk_raw_i,
  // Clock controls
  output logic main_clk_en_o,
  output logic pll_power_o,
  output logic pll_clk_active_o,
  output logic main_src_pll_o,
  output logic mclk_tick_o,
  output logic core_clk_en_o,
  // PLL settings
  output logic [2:0] pll_in_div_o,
  output logic [3:0] pll_int_mult_o,
  output logic pll_frac_mode_o,
  output logic [15:0] pll_num_o,
  output logic [15:0] pll_den_o,
  // Parameter writes
  output logic param_wr_o,
  output logic [7:0] param_addr_o,
  output logic [7:0] param_data_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] clk_ctrl, den_h, den_l, num_h, num_l, int_set, lock_res;
  logic [7:0] core_en, irq_stat, irq_mask;
  logic [7:0] next_clk_ctrl, next_den_h, next_den_l, next_num_h, next_num_l;
  logic [7:0] next_int_set, next_lock_res, next_core_en, next_irq_stat, next_irq_mask;
  logic [7:0] next_rdata, next_param_addr, next_param_data;
  logic next_param_wr;
  logic locked, locked_d, next_locked_d;
  logic main_on, pll_en, mult_ok;
  logic wr_ok, wr_refused, pll_area;

  assign main_on = clk_ctrl[clock_pll_pkg::main_clock_enable_bit];
  assign pll_en = clk_ctrl[clock_pll_pkg::pll_enable_bit];
  assign mult_ok = int_set[clock_pll_pkg::int_mult_msb:clock_pll_pkg::int_mult_lsb]
    >= clock_pll_pkg::int_mult_min
    && int_set[clock_pll_pkg::int_mult_msb:clock_pll_pkg::int_mult_lsb]
    <= clock_pll_pkg::int_mult_max;

  // Clock control and the six PLL registers stay writable with the main clock off.
  assign pll_area = addr_i <= clock_pll_pkg::pll_lock_flag_offset;
  assign wr_ok = wr_i && (main_on || pll_area);
  assign wr_refused = wr_i && !pll_area && (!main_on
    || (addr_i >= clock_pll_pkg::param_base_offset
    && !core_en[clock_pll_pkg::core_clk_en_bit]));

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_clk_ctrl = clk_ctrl;
    next_den_h = den_h;
    next_den_l = den_l;
    next_num_h = num_h;
    next_num_l = num_l;
    next_int_set = int_set;
    next_lock_res = lock_res;
    next_core_en = core_en;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_param_wr = 1'b0;
    next_param_addr = param_addr_o;
    next_param_data = param_data_o;
    next_locked_d = locked;
    if (wr_ok) begin
      unique case (addr_i)
        clock_pll_pkg::clock_control_offset: next_clk_ctrl = wdata_i;
        clock_pll_pkg::pll_denominator_high_offset: next_den_h = wdata_i;
        clock_pll_pkg::pll_denominator_low_offset: next_den_l = wdata_i;
        clock_pll_pkg::pll_numerator_high_offset: next_num_h = wdata_i;
        clock_pll_pkg::pll_numerator_low_offset: next_num_l = wdata_i;
        clock_pll_pkg::pll_integer_setting_offset: next_int_set = wdata_i;
        clock_pll_pkg::pll_lock_flag_offset: next_lock_res = {wdata_i[7:1], 1'b0};
        clock_pll_pkg::core_enable_offset: next_core_en = {7'h00, wdata_i[0]};
        clock_pll_pkg::irq_status_offset: next_irq_stat = irq_stat & ~wdata_i;
        clock_pll_pkg::irq_mask_offset: next_irq_mask = {5'h00, wdata_i[2:0]};
        default: begin
          if (addr_i >= clock_pll_pkg::param_base_offset
              && core_en[clock_pll_pkg::core_clk_en_bit]) begin
            next_param_wr = 1'b1;
            next_param_addr = addr_i;
            next_param_data = wdata_i;
          end
        end
      endcase
    end
    // Events are applied after the clear so that a set in the same cycle wins.
    if (locked && !locked_d) begin
      next_irq_stat[clock_pll_pkg::irq_lock_gained_bit] = 1'b1;
    end
    if (!locked && locked_d) begin
      next_irq_stat[clock_pll_pkg::irq_lock_lost_bit] = 1'b1;
    end
    if (wr_refused) begin
      next_irq_stat[clock_pll_pkg::irq_write_refused_bit] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_ctrl <= clock_pll_pkg::byte_reset;
      den_h <= clock_pll_pkg::byte_reset;
      den_l <= clock_pll_pkg::byte_reset;
      num_h <= clock_pll_pkg::byte_reset;
      num_l <= clock_pll_pkg::byte_reset;
      int_set <= clock_pll_pkg::byte_reset;
      lock_res <= clock_pll_pkg::byte_reset;
      core_en <= clock_pll_pkg::byte_reset;
      irq_stat <= clock_pll_pkg::byte_reset;
      irq_mask <= clock_pll_pkg::byte_reset;
      param_wr_o <= 1'b0;
      param_addr_o <= 8'h00;
      param_data_o <= 8'h00;
      locked_d <= 1'b0;
    end else begin
      clk_ctrl <= next_clk_ctrl;
      den_h <= next_den_h;
      den_l <= next_den_l;
      num_h <= next_num_h;
      num_l <= next_num_l;
      int_set <= next_int_set;
      lock_res <= next_lock_res;
      core_en <= next_core_en;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      param_wr_o <= next_param_wr;
      param_addr_o <= next_param_addr;
      param_data_o <= next_param_data;
      locked_d <= next_locked_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        clock_pll_pkg::clock_control_offset: next_rdata = clk_ctrl;
        clock_pll_pkg::pll_denominator_high_offset: next_rdata = den_h;
        clock_pll_pkg::pll_denominator_low_offset: next_rdata = den_l;
        clock_pll_pkg::pll_numerator_high_offset: next_rdata = num_h;
        clock_pll_pkg::pll_numerator_low_offset: next_rdata = num_l;
        clock_pll_pkg::pll_integer_setting_offset: next_rdata = int_set;
        clock_pll_pkg::pll_lock_flag_offset: next_rdata = {lock_res[7:1], locked};
        clock_pll_pkg::core_enable_offset: next_rdata = core_en;
        clock_pll_pkg::irq_status_offset: next_rdata = irq_stat;
        clock_pll_pkg::irq_mask_offset: next_rdata = irq_mask;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  pll_lock_timer #(
    .lock_count(lock_count)
  ) lock_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .enable_i(pll_clk_active_o && mult_ok),
    .locked_o(locked)
  );

  assign main_clk_en_o = main_on;
  assign pll_power_o = pll_en;
  assign pll_clk_active_o = pll_en && main_on;
  assign main_src_pll_o = clk_ctrl[clock_pll_pkg::main_clock_source_select_bit];
  assign core_clk_en_o = core_en[clock_pll_pkg::core_clk_en_bit];
  assign pll_in_div_o = {1'b0, int_set[clock_pll_pkg::in_div_msb:clock_pll_pkg::in_div_lsb]}
    + 3'h1;
  assign pll_int_mult_o = int_set[clock_pll_pkg::int_mult_msb:clock_pll_pkg::int_mult_lsb];
  assign pll_frac_mode_o = int_set[clock_pll_pkg::pll_type_bit];
  assign pll_num_o = pll_frac_mode_o ? {num_h, num_l} : 16'h0000;
  assign pll_den_o = pll_frac_mode_o ? {den_h, den_l} : 16'h0000;
  assign irq_o = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////

  // Both clock sources come from outside and pass three flops before use.
  logic [2:0] ext_sync, pll_sync, next_ext_sync, next_pll_sync;
  logic ext_lvl, pll_lvl, next_ext_lvl, next_pll_lvl;
  logic div_phase, next_div_phase, next_mclk_tick, src_tick;

  always_comb begin
    next_ext_sync = {ext_sync[1:0], ext_clk_pin_i};
    next_pll_sync = {pll_sync[1:0], pll_clk_raw_i};
    next_ext_lvl = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_lvl;
    next_pll_lvl = (pll_sync[1] == pll_sync[2]) ? pll_sync[2] : pll_lvl;
    if (main_src_pll_o) begin
      src_tick = next_pll_lvl && !pll_lvl && pll_clk_active_o;
    end else begin
      src_tick = next_ext_lvl && !ext_lvl;
    end
    next_div_phase = div_phase;
    next_mclk_tick = 1'b0;
    if (!main_on) begin
      next_div_phase = 1'b0;
    end else if (src_tick) begin
      next_div_phase = !div_phase;
      next_mclk_tick = clk_ctrl[clock_pll_pkg::master_clock_divider_select_bit]
        || div_phase;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ext_sync <= 3'h0;
      pll_sync <= 3'h0;
      ext_lvl <= 1'b0;
      pll_lvl <= 1'b0;
      div_phase <= 1'b0;
      mclk_tick_o <= 1'b0;
    end else begin
      ext_sync <= next_ext_sync;
      pll_sync <= next_pll_sync;
      ext_lvl <= next_ext_lvl;
      pll_lvl <= next_pll_lvl;
      div_phase <= next_div_phase;
      mclk_tick_o <= next_mclk_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  chk_div_bypass: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    src_tick && main_on && clk_ctrl[clock_pll_pkg::master_clock_divider_select_bit]
    |=> mclk_tick_o)
    else $error("undivided source tick did not reach the master clock");

  chk_div_halve: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    src_tick && main_on && !clk_ctrl[clock_pll_pkg::master_clock_divider_select_bit]
    && !div_phase |=> !mclk_tick_o ##0 div_phase)
    else $error("divide by two passed the first source tick");

  chk_write_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_i && !main_on && addr_i == clock_pll_pkg::core_enable_offset
    |=> core_en == $past(core_en) && irq_stat[clock_pll_pkg::irq_write_refused_bit])
    else $error("write accepted while main clock off");

  chk_pll_clk_on: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_i && addr_i == clock_pll_pkg::clock_control_offset && wdata_i[0] && wdata_i[7]
    |=> pll_clk_active_o && main_clk_en_o)
    else $error("main clock enable did not enable the PLL clock");

  chk_param_block: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_i && addr_i >= clock_pll_pkg::param_base_offset && !core_clk_en_o
    |=> !param_wr_o)
    else $error("parameter write passed before core clock enable");

  chk_den_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_i && addr_i == clock_pll_pkg::pll_denominator_high_offset |=> den_h == $past(wdata_i))
    else $error("denominator high byte not stored");

  chk_den_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == clock_pll_pkg::pll_denominator_high_offset |=> rdata_o == $past(den_h))
    else $error("denominator high byte read back wrong");

  chk_num_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == clock_pll_pkg::pll_numerator_low_offset |=> rdata_o == $past(num_l))
    else $error("numerator low byte read back wrong");

  chk_lock_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == clock_pll_pkg::pll_lock_flag_offset |=> rdata_o[0] == $past(locked))
    else $error("lock flag read back wrong");

  chk_int_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !int_set[clock_pll_pkg::pll_type_bit] |-> pll_num_o == 16'h0000 && pll_den_o == 16'h0000)
    else $error("fraction visible in integer mode");

  chk_lock_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pll_en |=> !locked)
    else $error("lock stayed with PLL disabled");

endmodule

`default_nettype wire

//--- verif/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none

// Plays host software on the register port; each task owns the port until it returns.
module host_port_model (
  // Clock
  input wire logic clk_sys_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A released bus shows the inverse of its last address, and after a write the inverse of its data too.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule

`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_sys_i, rst_i, wr_i, rd_i, ext_clk_pin_i, pll_clk_raw_i;
  logic [7:0] addr_i, wdata_i, rdata_o, param_addr_o, param_data_o, rv;
  logic main_clk_en_o, pll_power_o, pll_clk_active_o, main_src_pll_o;
  logic mclk_tick_o, core_clk_en_o, pll_frac_mode_o, param_wr_o, irq_o;
  logic [2:0] pll_in_div_o;
  logic [3:0] pll_int_mult_o;
  logic [15:0] pll_num_o, pll_den_o;
  int mismatches, check_count, ticks, params;

  clock_pll_config_bank #(.lock_count(8)) u_dut (
    .clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ext_clk_pin_i, .pll_clk_raw_i, .main_clk_en_o, .pll_power_o,
    .pll_clk_active_o, .main_src_pll_o, .mclk_tick_o, .core_clk_en_o,
    .pll_in_div_o, .pll_int_mult_o, .pll_frac_mode_o, .pll_num_o, .pll_den_o,
    .param_wr_o, .param_addr_o, .param_data_o, .irq_o
  );

  host_port_model u_host (
    .clk_sys_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
    .rdata_i(rdata_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (mclk_tick_o === 1'b1) ticks++;
    if (param_wr_o === 1'b1) params++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host.read_reg(a, rv);
    check(rv, e);
  endtask

  // Sends n pin pulses, each long enough to pass the input synchroniser.
  task automatic pulse_pin(input bit pll, input int n);
    ticks = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      if (pll) pll_clk_raw_i <= 1'b1;
      else ext_clk_pin_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      pll_clk_raw_i <= 1'b0;
      ext_clk_pin_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
    repeat (8) @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    @(negedge clk_sys_i);
    check(pll_in_div_o, 16'h1);
    check({main_clk_en_o, pll_clk_active_o, core_clk_en_o, irq_o}, 16'h0);
    for (int i = 1; i <= 6; i++) rd_chk(8'(i), 8'h00);
  endtask

  task automatic sc_gating();
    wr(8'h10, 8'h01);
    wr(8'h12, 8'h04);
    @(negedge clk_sys_i);
    check(core_clk_en_o, 16'h0);
    rd_chk(8'h12, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'(1 + i), 8'(8'h12 + 8'h22 * i));
    wr(8'h05, 8'h01);
    wr(8'h06, 8'hff);
    for (int i = 0; i < 4; i++) rd_chk(8'(1 + i), 8'(8'h12 + 8'h22 * i));
    rd_chk(8'h06, 8'hfe);
    check(pll_den_o, 16'h1234);
    check(pll_num_o, 16'h5678);
    check(pll_frac_mode_o, 16'h1);
    rd_chk(8'h11, 8'h04);
  endtask

  task automatic sc_int_setting();
    for (int i = 0; i < 7; i++) begin
      wr(8'h05, {1'b0, 4'(i + 2), 2'(i), 1'b0});
      @(negedge clk_sys_i);
      check(pll_int_mult_o, 16'(i + 2));
      check(pll_in_div_o, 16'(i % 4 + 1));
      check(pll_frac_mode_o, 16'h0);
      check(pll_num_o | pll_den_o, 16'h0);
    end
  endtask

  task automatic sc_tick();
    wr(8'h00, 8'h01);
    pulse_pin(1'b0, 6);
    check(16'(ticks), 16'h3);
    wr(8'h00, 8'h03);
    pulse_pin(1'b0, 6);
    check(16'(ticks), 16'h6);
    wr(8'h00, 8'h02);
    pulse_pin(1'b0, 2);
    check(16'(ticks), 16'h0);
  endtask

  task automatic sc_param_irq();
    wr(8'h00, 8'h01);
    params = 0;
    wr(8'h90, 8'h11);
    repeat (2) @(posedge clk_sys_i);
    check(16'(params), 16'h0);
    wr(8'h12, 8'h04);
    @(negedge clk_sys_i);
    check(irq_o, 16'h1);
    wr(8'h11, 8'h04);
    @(negedge clk_sys_i);
    check(irq_o, 16'h0);
    wr(8'h10, 8'h01);
    wr(8'h90, 8'ha5);
    repeat (2) @(posedge clk_sys_i);
    check(16'(params), 16'h1);
    check({param_addr_o, param_data_o}, 16'h90a5);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h10, 8'h01);
  endtask

  task automatic sc_lock();
    wr(8'h00, 8'h00);
    wr(8'h05, 8'h20);
    wr(8'h00, 8'h01);
    wr(8'h12, 8'h01);
    wr(8'h11, 8'h07);
    wr(8'h00, 8'h80);
    @(negedge clk_sys_i);
    check({pll_power_o, pll_clk_active_o}, 16'h2);
    wr(8'h00, 8'h81);
    @(negedge clk_sys_i);
    check(pll_clk_active_o, 16'h1);
    rd_chk(8'h06, 8'hfe);
    for (int n = 0; n < 40 && rv[0] !== 1'b1; n++) u_host.read_reg(8'h06, rv);
    check(rv[0], 16'h1);
    if (rv[0] !== 1'b1) give_verdict();
    @(negedge clk_sys_i);
    check(irq_o, 16'h1);
    wr(8'h11, 8'h01);
    wr(8'h00, 8'h8b);
    @(negedge clk_sys_i);
    check({pll_power_o, main_src_pll_o, pll_clk_active_o}, 16'h7);
    pulse_pin(1'b1, 4);
    check(16'(ticks), 16'h4);
    check(irq_o, 16'h0);
    wr(8'h00, 8'h0b);
    @(negedge clk_sys_i);
    check({pll_power_o, main_src_pll_o, pll_clk_active_o}, 16'h2);
    pulse_pin(1'b1, 4);
    check(16'(ticks), 16'h0);
    rd_chk(8'h06, 8'hfe);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    ext_clk_pin_i = 1'b0;
    pll_clk_raw_i = 1'b0;
    rv = 8'h00;
    mismatches = 0;
    check_count = 0;
    ticks = 0;
    params = 0;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    sc_reset();
    sc_gating();
    sc_int_setting();
    sc_tick();
    sc_param_irq();
    sc_lock();
    give_verdict();
  end
endmodule

`default_nettype wire
